// ### rtl/stc_pkg.sv
package stc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] STC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] STC_OFF_LOW     = 8'h04;
  localparam logic [7:0] STC_OFF_HIGH    = 8'h08;
  localparam logic [7:0] STC_OFF_GATE    = 8'h0c;
  localparam logic [7:0] STC_OFF_FLAGS   = 8'h10;
  localparam logic [7:0] STC_OFF_PINS    = 8'h14;

  // ****************************************
  // Control, gate and flag fields
  // ****************************************
  localparam int STC_BIT_RUN    = 0;
  localparam int STC_BIT_WIDE   = 1;
  localparam int STC_BIT_NOSYNC = 2;
  localparam int STC_BIT_OSCEN  = 3;
  localparam int STC_POS_PRESC  = 4;
  localparam int STC_POS_CSRC   = 6;
  localparam int STC_BIT_GATEEN = 7;
  localparam int STC_BIT_OVF_A  = 1;
  localparam int STC_BIT_OVF_B  = 3;
  localparam int STC_BIT_GEVT   = 7;

  localparam logic [7:0] STC_RST_CONTROL = 8'h00;
  localparam logic [7:0] STC_RST_GATE    = 8'h00;
  localparam logic [7:0] STC_RST_FLAGS   = 8'h00;
  localparam logic [1:0] STC_INSTR_DIV   = 2'h3;

  typedef enum logic [1:0] {
    STC_SRC_INSTR = 2'b00,
    STC_SRC_SYS   = 2'b01,
    STC_SRC_EXT   = 2'b10,
    STC_SRC_RSVD  = 2'b11
  } stc_src_e;

  typedef enum logic [1:0] {
    STC_ARM_WAIT_LOW = 2'b00,
    STC_ARM_READY    = 2'b01
  } stc_arm_e;

endpackage : stc_pkg

// ### rtl/stc_sync.sv
`timescale 1ns/100ps
module stc_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  import stc_pkg::*;

  logic meta;

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : stc_sync

// ### rtl/stc_presc.sv
`timescale 1ns/100ps
module stc_presc (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] ratio,
  output logic            tick_out
);
  import stc_pkg::*;

  logic [2:0] cnt;
  logic [2:0] mask;

  // ****************************************
  // Divide by 1, 2, 4 or 8
  // ****************************************
  always_comb begin
    case (ratio)
      2'b00:   mask = 3'h0;
      2'b01:   mask = 3'h1;
      2'b10:   mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  assign tick_out = tick_in && ((cnt & mask) == mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
    end else if (clear) begin
      cnt <= 3'h0;
    end else if (tick_in) begin
      cnt <= cnt + 3'h1;
    end
  end

endmodule : stc_presc

// ### rtl/stc_timer.sv
`timescale 1ns/100ps
// Function
// - Incrementing counter read through byte pair
// - Internal source counts each instruction cycle
// - Internal source steps on oscillator multiples
// - External pin counts rising edges, optionally synced
// - Source field selects instr, system, external
// - External uses pin or crystal by enable
// - Oscillator enable bit three
// - Prescaler divides by 1, 2, 4, 8
// - Sync control disables external synchronisation
// - Source 0x ignores sync control
// - Wide access selects 16-bit transfers
// - Run bit zero starts and stops
// - Run and gate enable together enable
// - Falling edge needed before first external count
// - Crystal pins become inputs reading zero
// - Overflow sets flag, software clears it
module stc_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_clock_pin,
  input  wire logic        secondary_oscillator,
  input  wire logic        gate_event,
  input  wire logic [1:0]  osc_pin_in,
  output logic             osc_pins_are_inputs,
  output logic [15:0]      count_value,
  output logic             overflow_pulse
);
  import stc_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  timer_control;
  logic [7:0]  gate_control;
  logic [7:0]  peripheral_flags_five;
  logic [15:0] count;
  logic [7:0]  high_read_buf;
  logic [7:0]  high_write_buf;
  logic [1:0]  instr_div;
  stc_arm_e    arm;
  logic        ext_prev;
  logic        ext_sync;

  logic        wr;
  logic        rd;
  logic        wr_low;
  logic        wr_high;
  logic        wr_flags;
  logic        timer_run;
  logic        gate_enable;
  logic        enabled;
  logic        wide_access_enable;
  logic        secondary_osc_enable;
  logic        external_sync_disable;
  logic [1:0]  clock_source_select;
  logic [1:0]  prescale_select;
  logic        ext_raw;
  logic        ext_level;
  logic        base_tick;
  logic        presc_tick;
  logic        step;
  logic        wrap;
  logic        known_addr;
  logic [31:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign wr_low  = wr && hit(paddr, STC_OFF_LOW);
  assign wr_high = wr && hit(paddr, STC_OFF_HIGH);
  assign wr_flags = wr && hit(paddr, STC_OFF_FLAGS);
  assign pready  = 1'b1;
  assign known_addr = hit(paddr, STC_OFF_CONTROL) || hit(paddr, STC_OFF_LOW) ||
                      hit(paddr, STC_OFF_HIGH) || hit(paddr, STC_OFF_GATE) ||
                      hit(paddr, STC_OFF_FLAGS) || hit(paddr, STC_OFF_PINS);
  assign pslverr = psel && penable && !known_addr;

  // ****************************************
  // Control fields
  // ****************************************
  assign timer_run             = timer_control[STC_BIT_RUN];
  assign wide_access_enable    = timer_control[STC_BIT_WIDE];
  assign external_sync_disable = timer_control[STC_BIT_NOSYNC];
  assign secondary_osc_enable  = timer_control[STC_BIT_OSCEN];
  assign prescale_select       = timer_control[STC_POS_PRESC +: 2];
  assign clock_source_select   = timer_control[STC_POS_CSRC +: 2];
  assign gate_enable           = gate_control[STC_BIT_GATEEN];
  assign enabled               = timer_run && gate_enable;

  // ****************************************
  // Clock source selection
  // ****************************************
  assign ext_raw   = secondary_osc_enable ? secondary_oscillator
                                          : external_clock_pin;
  assign ext_level = external_sync_disable ? ext_raw : ext_sync;
  assign osc_pins_are_inputs = secondary_osc_enable &&
                               (clock_source_select == STC_SRC_EXT);

  stc_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_raw),
    .sync_out (ext_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  // Falling edge arms the external counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm <= STC_ARM_WAIT_LOW;
    end else if (!enabled || wr_low || wr_high) begin
      arm <= STC_ARM_WAIT_LOW;
    end else begin
      case (arm)
        STC_ARM_WAIT_LOW: if (ext_prev && !ext_level) arm <= STC_ARM_READY;
        STC_ARM_READY:    arm <= STC_ARM_READY;
        default:          arm <= STC_ARM_WAIT_LOW;
      endcase
    end
  end

  always_comb begin
    case (clock_source_select)
      STC_SRC_INSTR: base_tick = (instr_div == STC_INSTR_DIV);
      STC_SRC_SYS:   base_tick = 1'b1;
      STC_SRC_EXT:   base_tick = (arm == STC_ARM_READY) && !ext_prev && ext_level;
      default:       base_tick = 1'b0;
    endcase
  end

  stc_presc u_presc (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (!enabled),
    .tick_in  (base_tick && enabled),
    .ratio    (prescale_select),
    .tick_out (presc_tick)
  );

  assign step = presc_tick && !wr_low && !wr_high;
  assign wrap = step && (count == 16'hffff);
  assign overflow_pulse = wrap;
  assign count_value = count;

  // ****************************************
  // Counter and byte access
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (wr_low) begin
      if (wide_access_enable) begin
        count <= {high_write_buf, pwdata[7:0]};
      end else begin
        count[7:0] <= pwdata[7:0];
      end
    end else if (wr_high && !wide_access_enable) begin
      count[15:8] <= pwdata[7:0];
    end else if (step) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_write_buf <= 8'h00;
    end else if (wr_high) begin
      high_write_buf <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_read_buf <= 8'h00;
    end else if (rd && hit(paddr, STC_OFF_LOW)) begin
      high_read_buf <= count[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control <= STC_RST_CONTROL;
      gate_control  <= STC_RST_GATE;
    end else if (wr && hit(paddr, STC_OFF_CONTROL)) begin
      timer_control <= pwdata[7:0];
    end else if (wr && hit(paddr, STC_OFF_GATE)) begin
      gate_control <= pwdata[7:0];
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_flags_five <= STC_RST_FLAGS;
    end else begin
      if (wr_flags) begin
        peripheral_flags_five <= pwdata[7:0];
      end
      if (wrap) begin
        peripheral_flags_five[STC_BIT_OVF_A] <= 1'b1;
      end
      if (gate_event) begin
        peripheral_flags_five[STC_BIT_GEVT] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      STC_OFF_CONTROL: next_rdata[7:0] = timer_control;
      STC_OFF_LOW:     next_rdata[7:0] = count[7:0];
      STC_OFF_HIGH:    next_rdata[7:0] = wide_access_enable ? high_read_buf
                                                            : count[15:8];
      STC_OFF_GATE:    next_rdata[7:0] = gate_control;
      STC_OFF_FLAGS:   next_rdata[7:0] = peripheral_flags_five;
      STC_OFF_PINS:    next_rdata[1:0] = osc_pins_are_inputs ? 2'b00 : osc_pin_in;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  assign prdata = next_rdata;

  // ****************************************
  // Checks
  // ****************************************
  a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wrap |=> peripheral_flags_five[STC_BIT_OVF_A])
    else $error("overflow flag not set after wrap");
  a_wrap_to_zero: assert property (@(posedge pclk) disable iff (!presetn)
    wrap |=> (count == 16'h0000))
    else $error("counter did not wrap to zero");
  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer_run && !wr_low && !wr_high) |=> (count == $past(count)))
    else $error("counter moved while stopped");
  a_gate_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (!gate_enable && !wr_low && !wr_high) |=> $stable(count))
    else $error("counter moved while gate disabled");
  a_sys_counts: assert property (@(posedge pclk) disable iff (!presetn)
    (enabled && clock_source_select == STC_SRC_SYS && prescale_select == 2'b00 &&
     !wr_low && !wr_high) |=> (count == $past(count) + 16'h0001))
    else $error("system clock source did not count");
  a_instr_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_source_select == STC_SRC_INSTR && base_tick) |=>
    !(clock_source_select == STC_SRC_INSTR && base_tick) [*3])
    else $error("instruction tick too frequent");
  a_arm_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_low || wr_high) |=> (arm == STC_ARM_WAIT_LOW))
    else $error("write did not disarm counter");
  a_wide_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_low && wide_access_enable) |=> (count[15:8] == $past(high_write_buf)))
    else $error("buffered high byte not transferred");
  a_pin_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (osc_pins_are_inputs && rd && paddr == STC_OFF_PINS) |-> (prdata[1:0] == 2'b00))
    else $error("crystal pins read nonzero");
  a_gate_flag: assert property (@(posedge pclk) disable iff (!presetn)
    gate_event |=> peripheral_flags_five[STC_BIT_GEVT])
    else $error("gate flag not set");

  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap);
  c_ext_step: cover property (@(posedge pclk) disable iff (!presetn)
    step && clock_source_select == STC_SRC_EXT);
  c_wide_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_low && wide_access_enable);
  c_presc8: cover property (@(posedge pclk) disable iff (!presetn)
    step && prescale_select == 2'b11);

endmodule : stc_timer

// ### verif/stc_ext_src.sv
`timescale 1ns/100ps
module stc_ext_src (
  input  wire logic pclk,
  output logic      external_clock_pin,
  output logic      secondary_oscillator
);
  // ****************************************
  // Pulse source, still between bursts
  // ****************************************
  initial begin
    external_clock_pin   = 1'b0;
    secondary_oscillator = 1'b0;
  end

  task pulses(input logic use_osc, input int n);
    repeat (n) begin
      repeat (5) @(posedge pclk);
      if (use_osc) secondary_oscillator <= 1'b1;
      else external_clock_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      secondary_oscillator <= 1'b0;
      external_clock_pin   <= 1'b0;
    end
  endtask : pulses
endmodule : stc_ext_src

// ### verif/tb.sv
`timescale 1ns/100ps
module tb;
  import stc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic        gate_event, osc_pins_are_inputs, overflow_pulse, ext_pin, osc_clk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [1:0]  osc_pin_in;
  logic [15:0] count_value, c0;
  int          errors, n_checks, i;

  stc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_pin(ext_pin), .secondary_oscillator(osc_clk),
    .gate_event(gate_event), .osc_pin_in(osc_pin_in),
    .osc_pins_are_inputs(osc_pins_are_inputs), .count_value(count_value),
    .overflow_pulse(overflow_pulse));
  stc_ext_src src (.pclk(pclk), .external_clock_pin(ext_pin), .secondary_oscillator(osc_clk));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task close_out;
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      errors++;
      close_out();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data, {24'h0, exp});
  endtask : rd

  task meas(input int cyc, input logic [15:0] exp);
    repeat (8) @(posedge pclk);
    #1 c0 = count_value;
    repeat (cyc) @(posedge pclk);
    #1 chk({16'h0, count_value - c0}, {16'h0, exp});
  endtask : meas

  task ext_run(input logic [7:0] ctrl, input logic use_osc, input logic [15:0] exp);
    wr(STC_OFF_CONTROL, 8'h00);
    wr(STC_OFF_LOW, 8'h00);
    wr(STC_OFF_HIGH, 8'h00);
    wr(STC_OFF_CONTROL, ctrl);
    src.pulses(use_osc, 4);
    repeat (5) @(posedge pclk);
    #1 chk({16'h0, count_value}, {16'h0, exp});
  endtask : ext_run

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    gate_event = 1'b0;
    osc_pin_in = 2'h3;
    errors     = 0;
    n_checks   = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(STC_OFF_CONTROL, STC_RST_CONTROL);
    rd(STC_OFF_GATE, STC_RST_GATE);
    rd(STC_OFF_FLAGS, STC_RST_FLAGS);
    rd(STC_OFF_LOW, 8'h00);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd_data, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    wr(STC_OFF_GATE, 8'h80);
    wr(STC_OFF_CONTROL, 8'h01);
    meas(40, 16'd10);
    wr(STC_OFF_CONTROL, 8'h05);
    meas(40, 16'd10);
    for (i = 0; i < 4; i++) begin
      wr(STC_OFF_CONTROL, 8'(8'h41 | (i << 4)));
      meas(64, 16'(64 >> i));
    end
    wr(STC_OFF_CONTROL, 8'hc1);
    meas(40, 16'd0);
    wr(STC_OFF_CONTROL, 8'h40);
    meas(40, 16'd0);
    wr(STC_OFF_GATE, 8'h00);
    wr(STC_OFF_CONTROL, 8'h41);
    meas(40, 16'd0);
    wr(STC_OFF_GATE, 8'h80);
    ext_run(8'h81, 1'b0, 16'd3);
    rd(STC_OFF_PINS, 8'h03);
    chk({31'h0, osc_pins_are_inputs}, 32'h0);
    ext_run(8'h85, 1'b0, 16'd3);
    ext_run(8'h89, 1'b1, 16'd3);
    src.pulses(1'b0, 3);
    #1 chk({16'h0, count_value}, 32'h3);
    rd(STC_OFF_PINS, 8'h00);
    chk({31'h0, osc_pins_are_inputs}, 32'h1);
    wr(STC_OFF_CONTROL, 8'h00);
    wr(STC_OFF_LOW, 8'h34);
    wr(STC_OFF_HIGH, 8'h12);
    #1 chk({16'h0, count_value}, 32'h1234);
    rd(STC_OFF_HIGH, 8'h12);
    wr(STC_OFF_CONTROL, 8'h02);
    wr(STC_OFF_HIGH, 8'hab);
    #1 chk({16'h0, count_value}, 32'h1234);
    wr(STC_OFF_LOW, 8'hcd);
    #1 chk({16'h0, count_value}, 32'habcd);
    rd(STC_OFF_LOW, 8'hcd);
    wr(STC_OFF_HIGH, 8'h55);
    rd(STC_OFF_HIGH, 8'hab);
    wr(STC_OFF_CONTROL, 8'h00);
    wr(STC_OFF_FLAGS, 8'h00);
    wr(STC_OFF_LOW, 8'hfe);
    wr(STC_OFF_HIGH, 8'hff);
    wr(STC_OFF_CONTROL, 8'h41);
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      #1;
      if (overflow_pulse === 1'b1) break;
    end
    if (i == 50) begin
      errors++;
      close_out();
    end
    @(posedge pclk);
    #1 chk({31'h0, overflow_pulse}, 32'h0);
    wr(STC_OFF_CONTROL, 8'h00);
    #1 chk({31'h0, count_value < 16'h0010}, 32'h1);
    rd(STC_OFF_FLAGS, 8'h02);
    wr(STC_OFF_FLAGS, 8'h00);
    rd(STC_OFF_FLAGS, 8'h00);
    @(posedge pclk);
    gate_event <= 1'b1;
    @(posedge pclk);
    gate_event <= 1'b0;
    rd(STC_OFF_FLAGS, 8'h80);
    wr(STC_OFF_FLAGS, 8'h08);
    rd(STC_OFF_FLAGS, 8'h08);
    close_out();
  end
endmodule : tb
